// ==== rtl/modem_tx_usart_encoder.v ====
// Transmit character engine, scrambler feed and FSK/DPSK symbol encoder.
`timescale 1ns/1ps
`include "modem_tx_regs.vh"
module modem_tx_usart_encoder #(
   parameter PER_W = 16
) (
   // Clock, reset and clock enable.
   input wire ref_clk,
   input wire reset_n,
   input wire clk_en,
   // Host write port, same clock domain.
   input wire host_wr,
   input wire [7:0] host_addr,
   input wire [7:0] host_wdata,
   // Mode and power control.
   input wire [2:0] tx_mode,
   input wire rx_enable,
   input wire standby,
   // Character framing control.
   input wire start_stop,
   input wire [1:0] data_bits,
   input wire parity_en,
   input wire parity_odd,
   input wire two_stop,
   // Scrambler, band, guard tone and equaliser control.
   input wire scram_en,
   input wire high_band,
   input wire guard_en,
   input wire guard_hi,
   input wire eq_en,
   // Bit rate clock from outside the domain.
   input wire bit_clk,
   // Status flags.
   output reg tx_data_ready_q,
   output reg tx_underflow_q,
   // Modulator controls.
   output reg line_bit_q,
   output reg fsk_hi_q,
   output reg [1:0] dpsk_phase_q,
   output reg sym_stb_q,
   output reg carrier_hi_q,
   output reg guard_on_q,
   output reg guard_hi_q,
   output reg eq_on_q,
   // Power state of each direction.
   output reg tx_power_q,
   output reg rx_power_q
);
   // Engine states.
   localparam S_IDLE = 3'h0;
   localparam S_START = 3'h1;
   localparam S_DATA = 3'h2;
   localparam S_PAR = 3'h3;
   localparam S_STOP = 3'h4;

   // True for either DPSK rate; used by several decisions.
   function is_dpsk;
      input [2:0] m;
      begin
         is_dpsk = (m == `TXM_DPSK600) || (m == `TXM_DPSK1200);
      end
   endfunction

   // Bit clock synchroniser and edge finder.
   reg bclk_s1_q;
   reg bclk_s2_q;
   reg bclk_s3_q;
   // Measured bit period and running counters, in ref_clk cycles.
   reg [PER_W-1:0] meas_q;
   reg [PER_W-1:0] period_q;
   reg [PER_W-1:0] pcnt_q;
   // Engine state.
   reg [2:0] st_q;
   reg [2:0] bitn_q;
   reg [7:0] buf_q;
   reg [7:0] sh_q;
   reg par_q;
   reg [1:0] stops_q;
   reg short_q;
   reg loaded_q;
   reg out_bit_q;
   // Holding register written by the host.
   reg [7:0] hreg_q;
   reg hfull_q;
   reg hshort_q;
   // Pipeline strobes toward scrambler and modulator.
   reg step_q;
   reg mod_q;
   reg half_q;
   reg first_q;
   wire scr_bit;

   // Transmit runs only in a modem mode and outside standby.
   wire modem_mode = is_dpsk(tx_mode) || tx_mode == `TXM_FSK;
   wire tx_on = modem_mode && !standby;
   wire fsk = tx_mode == `TXM_FSK;
   wire bclk_rise = bclk_s2_q && !bclk_s3_q;
   // Last stop bit of an alternate-address FSK character is shorter.
   wire cut = (st_q == S_STOP) && stops_q == 2'h1 && short_q && fsk;
   wire [PER_W-1:0] cur_len = cut ?
      period_q - (period_q >> `SHORT_SHIFT) : period_q;
   wire tick = tx_on && period_q != {PER_W{1'b0}} &&
      pcnt_q >= cur_len - {{(PER_W-1){1'b0}}, 1'b1};
   wire [2:0] last_bit = start_stop ? {1'b0, data_bits} + 3'h4 : 3'h7;
   wire data_wr = host_wr && (host_addr == `TXD_NORMAL_ADDR ||
      host_addr == `TXD_SHORT_ADDR);
   // Stop bits for the character being finished.
   wire [1:0] stops_cfg = two_stop ? 2'h2 : 2'h1;
   wire [1:0] stops_use = (short_q && is_dpsk(tx_mode)) ?
      stops_cfg - 2'h1 : stops_cfg;

   // The pin passes two flops; the third only serves edge detection.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bclk_s1_q <= 1'b0;
         bclk_s2_q <= 1'b0;
         bclk_s3_q <= 1'b0;
      end else if (clk_en) begin
         bclk_s1_q <= bit_clk;
         bclk_s2_q <= bclk_s1_q;
         bclk_s3_q <= bclk_s2_q;
      end
   end

   // The bit clock only sets the period; bits are timed internally so
   // a shortened stop does not have to wait for the next clock edge.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meas_q <= {PER_W{1'b0}};
         period_q <= {PER_W{1'b0}};
         pcnt_q <= {PER_W{1'b0}};
      end else if (clk_en) begin
         if (bclk_rise) begin
            period_q <= meas_q + {{(PER_W-1){1'b0}}, 1'b1};
            meas_q <= {PER_W{1'b0}};
         end else if (meas_q != {PER_W{1'b1}}) begin
            meas_q <= meas_q + {{(PER_W-1){1'b0}}, 1'b1};
         end
         if (tick || !tx_on) begin
            pcnt_q <= {PER_W{1'b0}};
         end else begin
            pcnt_q <= pcnt_q + {{(PER_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Load the next character from the host, or cover a late one.
   task fetch;
      begin
         if (hfull_q) begin
            buf_q <= hreg_q;
            short_q <= hshort_q;
            hfull_q <= 1'b0;
            loaded_q <= 1'b1;
            tx_data_ready_q <= 1'b1;
            if (start_stop) begin
               // The start bit is generated here, not taken from data.
               sh_q <= hreg_q;
               out_bit_q <= 1'b0;
               st_q <= S_START;
            end else begin
               sh_q <= {1'b0, hreg_q[7:1]};
               out_bit_q <= hreg_q[0];
               bitn_q <= 3'h0;
               st_q <= S_DATA;
            end
         end else begin
            if (loaded_q) begin
               tx_underflow_q <= 1'b1;
            end
            if (!start_stop && loaded_q) begin
               // Synchronous data repeats the old buffer.
               sh_q <= {1'b0, buf_q[7:1]};
               out_bit_q <= buf_q[0];
               bitn_q <= 3'h0;
               st_q <= S_DATA;
            end else begin
               // Extra stop level while waiting for the host.
               out_bit_q <= `MARK_LEVEL;
               st_q <= S_IDLE;
            end
         end
      end
   endtask

   // After the data bits or parity: the stop bits, or a fetch when none are due.
   task to_stop;
      begin
         if (stops_use == 2'h0) begin
            fetch;
         end else begin
            out_bit_q <= `MARK_LEVEL;
            stops_q <= stops_use;
            st_q <= S_STOP;
         end
      end
   endtask

   // Character engine and host holding register.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= S_IDLE;
         bitn_q <= 3'h0;
         buf_q <= 8'h00;
         sh_q <= 8'h00;
         par_q <= 1'b0;
         stops_q <= 2'h0;
         short_q <= 1'b0;
         loaded_q <= 1'b0;
         out_bit_q <= `MARK_LEVEL;
         hreg_q <= 8'h00;
         hfull_q <= 1'b0;
         hshort_q <= 1'b0;
         tx_data_ready_q <= `FLAG_RST;
         tx_underflow_q <= `FLAG_RST;
      end else if (clk_en) begin
         // A host write to either data address clears the flags; a set below in the same
         // cycle overrides it.
         if (data_wr) begin
            tx_data_ready_q <= 1'b0;
            tx_underflow_q <= 1'b0;
         end
         if (!tx_on) begin
            st_q <= S_IDLE;
            out_bit_q <= `MARK_LEVEL;
         end else if (tick) begin
            case (st_q)
               S_IDLE: begin
                  fetch;
               end
               S_START: begin
                  out_bit_q <= sh_q[0];
                  par_q <= sh_q[0];
                  sh_q <= {1'b0, sh_q[7:1]};
                  bitn_q <= 3'h0;
                  st_q <= S_DATA;
               end
               S_DATA: begin
                  if (bitn_q == last_bit) begin
                     if (!start_stop) begin
                        fetch;
                     end else if (parity_en) begin
                        out_bit_q <= par_q ^ parity_odd;
                        st_q <= S_PAR;
                     end else begin
                        to_stop;
                     end
                  end else begin
                     out_bit_q <= sh_q[0];
                     par_q <= par_q ^ sh_q[0];
                     sh_q <= {1'b0, sh_q[7:1]};
                     bitn_q <= bitn_q + 3'h1;
                  end
               end
               S_PAR: begin
                  to_stop;
               end
               S_STOP: begin
                  if (stops_q == 2'h1) begin
                     fetch;
                  end else begin
                     stops_q <= stops_q - 2'h1;
                  end
               end
               default: begin
                  st_q <= S_IDLE;
               end
            endcase
         end
         // Written last so a write in a fetch cycle is not lost.
         if (data_wr) begin
            hreg_q <= host_wdata;
            hfull_q <= 1'b1;
            // Synchronous data ignores which address was used.
            hshort_q <= (host_addr == `TXD_SHORT_ADDR) &&
               start_stop;
         end
      end
   end

   // Scrambler sees each engine bit one cycle after it is chosen.
   tx_scrambler #(
      .LEN(`SCR_TAP_B)
   ) u_scr (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .step(step_q),
      .enable(scram_en),
      .din(out_bit_q),
      .dout_q(scr_bit)
   );

   // Strobes that walk each bit through the scrambler to the encoder.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         step_q <= 1'b0;
         mod_q <= 1'b0;
      end else if (clk_en) begin
         step_q <= tick;
         mod_q <= step_q;
      end
   end

   // Symbol encoder: FSK tone choice or DPSK phase accumulation.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         line_bit_q <= `MARK_LEVEL;
         fsk_hi_q <= `MARK_LEVEL;
         dpsk_phase_q <= `PHASE_RST;
         sym_stb_q <= 1'b0;
         half_q <= 1'b0;
         first_q <= 1'b0;
      end else if (clk_en) begin
         sym_stb_q <= 1'b0;
         if (!tx_on) begin
            half_q <= 1'b0;
            line_bit_q <= `MARK_LEVEL;
         end else if (mod_q) begin
            line_bit_q <= scr_bit;
            case (tx_mode)
               `TXM_FSK: begin
                  // Tone pair comes from the mode, member from the bit.
                  fsk_hi_q <= scr_bit;
               end
               `TXM_DPSK600: begin
                  // One bit per symbol at 600 baud.
                  dpsk_phase_q <= dpsk_phase_q +
                     (scr_bit ? `PH_270 : `PH_90);
                  sym_stb_q <= 1'b1;
               end
               `TXM_DPSK1200: begin
                  // First bit of the pair is the left-hand bit.
                  if (!half_q) begin
                     first_q <= scr_bit;
                     half_q <= 1'b1;
                  end else begin
                     half_q <= 1'b0;
                     sym_stb_q <= 1'b1;
                     case ({first_q, scr_bit})
                        2'h0: dpsk_phase_q <= dpsk_phase_q + `PH_90;
                        2'h1: dpsk_phase_q <= dpsk_phase_q + `PH_0;
                        2'h3: dpsk_phase_q <= dpsk_phase_q + `PH_270;
                        default: dpsk_phase_q <= dpsk_phase_q + `PH_180;
                     endcase
                  end
               end
               default: begin
                  half_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Band, guard tone, equaliser and power states.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         carrier_hi_q <= 1'b0;
         guard_on_q <= 1'b0;
         guard_hi_q <= 1'b0;
         eq_on_q <= 1'b0;
         tx_power_q <= 1'b0;
         rx_power_q <= 1'b0;
      end else if (clk_en) begin
         carrier_hi_q <= high_band;
         // Guard tone only makes sense beside a DPSK carrier.
         guard_on_q <= guard_en && is_dpsk(tx_mode) && tx_on;
         guard_hi_q <= guard_hi;
         eq_on_q <= eq_en && tx_on;
         tx_power_q <= tx_mode != `TXM_OFF && !standby;
         rx_power_q <= rx_enable && !standby;
      end
   end
endmodule

// ==== rtl/modem_tx_regs.vh ====
// Constants for the modem transmit data path and its host write port.
// What this block does
// - Transmit and receive modes set independently, disableable.
// - Standby keeps only host port, ring logic.
// - Synchronous mode sends eight buffered bits, bit0 first.
// - Start-stop: start, 5-8 data, parity, stops.
// - Framing bits generated internally, never from data.
// - Buffer load sets the data ready flag.
// - Host data write clears the data ready flag.
// - Missed reload sets the underflow flag.
// - Underflow resends buffer or sends steady stop.
// - Data register answers at two write addresses.
// - DPSK alternate address drops one stop bit.
// - FSK alternate address shortens last stop eighth.
// - Synchronous mode treats both addresses alike.
// - Waiting start-stop engine inserts extra stop bits.
// - Scrambler inverts bit after 64 input ones.
// - Scrambler polynomial one plus taps 14, 17.
// - Engine feeds scrambler, then FSK or DPSK.
// - FSK picks tone from mode and bit.
// - DPSK carrier low or high band, 600 baud.
// - 600 bps: zero +90, one +270 degrees.
// - 1200 bps dibits mapped to phase changes.
// - DPSK modes may add 550 or 1800 Hz guard.
`ifndef MODEM_TX_REGS_VH
`define MODEM_TX_REGS_VH

// Write addresses of the transmit data register.
`define TXD_NORMAL_ADDR 8'hE3
`define TXD_SHORT_ADDR 8'hE4

// Transmit mode codes.
`define TXM_OFF 3'h0
`define TXM_FSK 3'h1
`define TXM_DPSK600 3'h2
`define TXM_DPSK1200 3'h3
`define TXM_TONE 3'h4

// Reset values of the flags, the line level and the phase.
`define FLAG_RST 1'b0
`define MARK_LEVEL 1'b1
`define PHASE_RST 2'h0

// Phase advances in quarter turns.
`define PH_0 2'h0
`define PH_90 2'h1
`define PH_180 2'h2
`define PH_270 2'h3

// Carrier and guard tone figures in hertz, symbol rate per second.
`define CARRIER_LO_HZ 1200
`define CARRIER_HI_HZ 2400
`define GUARD_LO_HZ 550
`define GUARD_HI_HZ 1800
`define SYMBOL_RATE 600

// Stop shortening is one eighth of a bit, done as a right shift.
`define SHORT_SHIFT 3

// Scrambler figures.
`define SCR_ONES_LIMIT 7'h40
`define SCR_TAP_A 14
`define SCR_TAP_B 17

`endif

// ==== rtl/tx_scrambler.v ====
// Self-synchronising transmit scrambler with a long-ones breaker.
`timescale 1ns/1ps
`include "modem_tx_regs.vh"
module tx_scrambler #(
   parameter LEN = `SCR_TAP_B
) (
   // Clock, reset and enable.
   input wire ref_clk,
   input wire reset_n,
   input wire clk_en,
   // Bit stream.
   input wire step,
   input wire enable,
   input wire din,
   output reg dout_q
);
   // Delay line, element 0 holds the newest scrambled bit.
   reg [LEN-1:0] sr_q;
   // Count of consecutive ones seen at the input.
   reg [6:0] ones_q;
   // Set when the next input bit must be inverted.
   reg inv_q;
   wire d_in;
   wire s_bit;
   wire [LEN-1:0] sr_d;
   genvar g;

   // The breaker acts on the input, before the polynomial.
   assign d_in = din ^ inv_q;
   assign s_bit = d_in ^ sr_q[`SCR_TAP_A-1] ^ sr_q[`SCR_TAP_B-1];
   assign sr_d[0] = s_bit;

   // Each stage takes the one before it on a step.
   generate
      for (g = 1; g < LEN; g = g + 1) begin : shift
         assign sr_d[g] = sr_q[g-1];
      end
   endgenerate

   // Advance once per bit; when disabled the bit passes untouched.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sr_q <= {LEN{1'b0}};
         ones_q <= 7'h00;
         inv_q <= 1'b0;
         dout_q <= `MARK_LEVEL;
      end else if (clk_en && step) begin
         if (enable) begin
            sr_q <= sr_d;
            dout_q <= s_bit;
            // Sixty-four ones in a row arm the inversion of the next bit.
            if (din && ones_q == `SCR_ONES_LIMIT - 7'h01) begin
               inv_q <= 1'b1;
               ones_q <= 7'h00;
            end else begin
               inv_q <= 1'b0;
               ones_q <= din ? ones_q + 7'h01 : 7'h00;
            end
         end else begin
            dout_q <= din;
            inv_q <= 1'b0;
            ones_q <= 7'h00;
         end
      end
   end
endmodule

// ==== testbench/modem_tx_usart_encoder_assertions.sv ====
// Port checker for the modem transmit encoder, bound to its top module.
`timescale 1ns/1ps
`include "modem_tx_regs.vh"
module modem_tx_checker (
   // Clock and reset.
   input wire ref_clk,
   input wire reset_n,
   input wire clk_en,
   // Host port and controls.
   input wire host_wr,
   input wire [7:0] host_addr,
   input wire [2:0] tx_mode,
   input wire rx_enable,
   input wire standby,
   // Watched outputs.
   input wire tx_data_ready_q,
   input wire tx_underflow_q,
   input wire [1:0] dpsk_phase_q,
   input wire sym_stb_q,
   input wire guard_on_q,
   input wire tx_power_q,
   input wire rx_power_q
);
   // One clock domain, so clocking and reset are stated once.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sym_pulse_a: assert property (sym_stb_q |=> !sym_stb_q)
      else $error("symbol strobe held too long");
   sym_mode_a: assert property (sym_stb_q |-> tx_mode inside
      {`TXM_DPSK600, `TXM_DPSK1200}) else $error("symbol outside DPSK");
   step600_a: assert property (sym_stb_q && tx_mode == `TXM_DPSK600
      |-> 2'(dpsk_phase_q - $past(dpsk_phase_q)) inside {`PH_90, `PH_270})
      else $error("bad 600 bps phase step");
   guard_mode_a: assert property (guard_on_q |-> $past(tx_mode) inside
      {`TXM_DPSK600, `TXM_DPSK1200}) else $error("guard tone outside DPSK");
   standby_off_a: assert property (clk_en && standby
      |=> !tx_power_q && !rx_power_q) else $error("power up in standby");
   rx_power_a: assert property (clk_en && !standby && rx_enable
      |=> rx_power_q) else $error("receive not powered");
   tx_off_a: assert property (clk_en && tx_mode == `TXM_OFF
      |=> !tx_power_q) else $error("transmit powered while off");
   ready_clear_a: assert property ($fell(tx_data_ready_q) && !$past(standby)
      |-> $past(host_wr && host_addr inside {`TXD_NORMAL_ADDR,
      `TXD_SHORT_ADDR})) else $error("ready dropped without a write");
   under_clear_a: assert property ($fell(tx_underflow_q)
      && !$past(standby) |-> $past(host_wr))
      else $error("underflow dropped without a write");
endmodule

bind modem_tx_usart_encoder modem_tx_checker chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
   .host_wr(host_wr), .host_addr(host_addr), .tx_mode(tx_mode),
   .rx_enable(rx_enable), .standby(standby),
   .tx_data_ready_q(tx_data_ready_q), .tx_underflow_q(tx_underflow_q),
   .dpsk_phase_q(dpsk_phase_q), .sym_stb_q(sym_stb_q),
   .guard_on_q(guard_on_q), .tx_power_q(tx_power_q),
   .rx_power_q(rx_power_q));

// ==== testbench/host_model.sv ====
// Host controller model that writes bytes into the transmit data register.
`timescale 1ns/1ps
module host_model (
   // Clock.
   input wire ref_clk,
   // Write port toward the encoder.
   output logic host_wr,
   output logic [7:0] host_addr,
   output logic [7:0] host_wdata
);
   // Idle lines start quiet; no write is made before the bench asks.
   initial begin
      host_wr = 1'b0;
      host_addr = 8'h00;
      host_wdata = 8'h00;
   end

   // One write held for exactly one edge; afterwards the address and data
   // lines show the inverse, so a stale value can never look valid.
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      host_wr <= 1'b1;
      host_addr <= addr;
      host_wdata <= data;
      @(posedge ref_clk);
      host_wr <= 1'b0;
      host_addr <= ~addr;
      host_wdata <= ~data;
   endtask
endmodule

// ==== testbench/modem_tx_usart_encoder_tb.sv ====
// Self-checking bench for the modem transmit encoder.
`timescale 1ns/1ps
`include "modem_tx_regs.vh"
module modem_tx_usart_encoder_tb;
   // Stimulus, all but md given values at time zero.
   logic ref_clk = 1'b0, reset_n = 1'b0, bit_clk = 1'b0, standby = 1'b0;
   logic rx_enable = 1'b1, start_stop = 1'b1, parity_en = 1'b1;
   logic parity_odd = 1'b1, two_stop = 1'b0, high_band = 1'b0;
   logic guard_en = 1'b1, guard_hi = 1'b0, eq_en = 1'b0, scram_en = 1'b0;
   logic [1:0] data_bits = 2'h3;
   logic [2:0] tx_mode = `TXM_FSK, md;
   wire host_wr;
   wire [7:0] host_addr, host_wdata;
   // Design outputs.
   wire tx_data_ready_q, tx_underflow_q, line_bit_q, fsk_hi_q, sym_stb_q;
   wire carrier_hi_q, guard_on_q, guard_hi_q, eq_on_q, tx_power_q;
   wire rx_power_q;
   wire [1:0] dpsk_phase_q;
   // Line recording and the expected per-cycle line level.
   logic rec_q[$], exp_q[$];
   int bad_count = 0, n_tests = 0, cycles = 0, ns;
   // Scrambler break positions and per-cycle monitor tallies.
   int zl = -1, zn = 0, gap_bad = 0, fsk_bad = 0, ph_bad = 0, n_sym = 0;
   logic [1:0] ph_prev, ph_step;
   logic [2:0] md_q;
   logic lb_prev;
   localparam int CYC = 8; // Bit period in ref_clk cycles at 200 ns.

   modem_tx_usart_encoder uut (.ref_clk(ref_clk), .reset_n(reset_n),
      .clk_en(1'b1), .host_wr(host_wr), .host_addr(host_addr),
      .host_wdata(host_wdata), .tx_mode(tx_mode), .rx_enable(rx_enable),
      .standby(standby), .start_stop(start_stop), .data_bits(data_bits),
      .parity_en(parity_en), .parity_odd(parity_odd), .two_stop(two_stop),
      .scram_en(scram_en), .high_band(high_band), .guard_en(guard_en),
      .guard_hi(guard_hi), .eq_en(eq_en), .bit_clk(bit_clk),
      .tx_data_ready_q(tx_data_ready_q), .tx_underflow_q(tx_underflow_q),
      .line_bit_q(line_bit_q), .fsk_hi_q(fsk_hi_q),
      .dpsk_phase_q(dpsk_phase_q), .sym_stb_q(sym_stb_q),
      .carrier_hi_q(carrier_hi_q), .guard_on_q(guard_on_q),
      .guard_hi_q(guard_hi_q), .eq_on_q(eq_on_q),
      .tx_power_q(tx_power_q), .rx_power_q(rx_power_q));
   host_model host (.ref_clk(ref_clk), .host_wr(host_wr),
      .host_addr(host_addr), .host_wdata(host_wdata));

   // Clocks; the bit clock is offset so its edges never meet ref_clk's.
   initial forever #12.5 ref_clk = ~ref_clk;
   initial begin
      #37;
      forever #100 bit_clk = ~bit_clk;
   end

   // Record the line every cycle from the first low level onward, and
   // hold the tone member and each phase step against the bit sent.
   // The mode is taken one cycle late, as the design saw it.
   always @(posedge ref_clk) begin
      if (rec_q.size() > 0 || line_bit_q === 1'b0)
         rec_q.push_back(line_bit_q);
      if (md_q == `TXM_FSK && fsk_hi_q !== line_bit_q)
         fsk_bad++;
      if (sym_stb_q === 1'b1) begin
         if (md_q == `TXM_DPSK1200)
            n_sym++;
         ph_step = (md_q == `TXM_DPSK600) ?
            (line_bit_q ? `PH_270 : `PH_90) : !lb_prev ?
            (line_bit_q ? `PH_0 : `PH_90) : (line_bit_q ? `PH_270 : `PH_180);
         if (2'(dpsk_phase_q - ph_prev) !== ph_step)
            ph_bad++;
      end
      md_q <= tx_mode;
      ph_prev <= dpsk_phase_q;
      lb_prev <= line_bit_q;
   end

   // A hang counts as a mismatch and closes the run.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         $display("BAD timeout expected done seen hang");
         final_report();
      end
   end

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic put(input logic lvl, input int n);
      repeat (n) exp_q.push_back(lvl);
   endtask

   // Expected levels of one start-stop character; cut trims one cycle,
   // which is an eighth of the last stop bit.
   task automatic put_char(input logic [7:0] b, input int nstop,
      input logic cut);
      put(1'b0, CYC);
      for (int i = 0; i < data_bits + 5; i++) put(b[i], CYC);
      if (parity_en)
         put(^(b & ((8'h01 << (data_bits + 5)) - 8'h01)) ^ parity_odd, CYC);
      put(1'b1, CYC * nstop);
      if (cut) void'(exp_q.pop_back());
   endtask

   task automatic start_rec();
      rec_q.delete();
      exp_q.delete();
   endtask

   // Wait for the byte to be taken into the buffer (ready goes high).
   task automatic wait_ready();
      int n;
      n = 0;
      repeat (2) @(posedge ref_clk);
      while (tx_data_ready_q !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
   endtask

   // Wait for the recording to cover the expectation, then compare.
   task automatic cmp_stream(input string what);
      int bad_at, n;
      bad_at = -1;
      n = 0;
      while (rec_q.size() < exp_q.size() && n < 3000) begin
         @(posedge ref_clk);
         n++;
      end
      for (int i = 0; i < exp_q.size(); i++)
         if (bad_at < 0 && (i >= rec_q.size() || rec_q[i] !== exp_q[i]))
            bad_at = i;
      check(what, bad_at, -1);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      // Power and idle level.
      repeat (40) @(posedge ref_clk);
      check("idle line", line_bit_q, 1'b1);
      check("powers", {tx_power_q, rx_power_q}, 2'b11);
      standby <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check("standby power", {tx_power_q, rx_power_q}, 2'b00);
      standby <= 1'b0;
      rx_enable <= 1'b0;
      repeat (40) @(posedge ref_clk);
      check("rx off tx on", {tx_power_q, rx_power_q}, 2'b10);
      $display("test power done");
      // Two characters back to back, then underflow and steady stop level.
      start_rec();
      host.write(`TXD_NORMAL_ADDR, 8'hA5);
      wait_ready();
      check("ready on load", tx_data_ready_q, 1'b1);
      host.write(`TXD_NORMAL_ADDR, 8'h0F);
      repeat (2) @(posedge ref_clk);
      check("ready on write", tx_data_ready_q, 1'b0);
      put_char(8'hA5, 1, 1'b0);
      put_char(8'h0F, 1, 1'b0);
      put(1'b1, CYC * 4);
      cmp_stream("start stop chars");
      check("underflow", tx_underflow_q, 1'b1);
      $display("test start stop done");
      // Alternate address in each modem mode, third with two stops.
      for (int m = 0; m < 3; m++) begin
         md = (m == 0) ? `TXM_FSK : (m == 1) ? `TXM_DPSK600 : `TXM_DPSK1200;
         tx_mode <= md;
         two_stop <= (m == 2);
         parity_en <= 1'b0;
         high_band <= (m == 1);
         guard_hi <= (m == 2);
         eq_en <= (m == 1);
         repeat (40) @(posedge ref_clk);
         start_rec();
         host.write(`TXD_NORMAL_ADDR, 8'h00);
         wait_ready();
         host.write(`TXD_SHORT_ADDR, 8'h81);
         wait_ready();
         host.write(`TXD_NORMAL_ADDR, 8'hFF);
         ns = two_stop ? 2 : 1;
         put_char(8'h00, ns, 1'b0);
         put_char(8'h81, (m == 0) ? ns : ns - 1, m == 0);
         put_char(8'hFF, ns, 1'b0);
         put(1'b1, CYC);
         cmp_stream("short stop chars");
         check("guard on", guard_on_q, m != 0);
         check("guard pick", guard_hi_q, m == 2);
         check("carrier band", carrier_hi_q, m == 1);
         check("equaliser", eq_on_q, m == 1);
         $display("test alternate address mode %0d done", m);
      end
      // Synchronous mode: alternate address acts as normal, byte resent.
      start_stop <= 1'b0;
      repeat (40) @(posedge ref_clk);
      start_rec();
      host.write(`TXD_SHORT_ADDR, 8'h3C);
      repeat (3) for (int i = 0; i < 8; i++) put(1'(8'h3C >> i), CYC);
      cmp_stream("sync resend");
      check("sync underflow", tx_underflow_q, 1'b1);
      $display("test synchronous done");
      // Scrambler on a steady stop level: descrambling the line must give
      // back ones, broken by one inverted bit after each run of ones.
      start_stop <= 1'b1;
      scram_en <= 1'b1;
      repeat (120) @(posedge ref_clk);
      start_rec();
      while (rec_q.size() < CYC * 200) @(posedge ref_clk);
      for (int k = 17; k < 200; k++)
         if ((rec_q[CYC * k + 4] ^ rec_q[CYC * (k - 14) + 4] ^
            rec_q[CYC * (k - 17) + 4]) === 1'b0) begin
            if (zl >= 0 && k - zl != 64)
               gap_bad++;
            zl = k;
            zn++;
         end
      check("scrambler gaps", gap_bad, 0);
      check("scrambler breaks", zn >= 2, 1);
      check("fsk tone", fsk_bad, 0);
      check("phase steps", ph_bad, 0);
      check("dibit symbols", n_sym > 0, 1);
      $display("test scrambler done");
      final_report();
   end
endmodule
